// >>> include/apms_pkg.sv
// package: register map, pin map, modes and timing constants of the audio pin mux and status block
// Behaviour
// - slave audio mode drives word clock, bit clock and four data lines on shared pins
// - slave audio bit clock appears on the eighth register-controlled pin
// - slave audio data lines A to D each drive their own shared pin
// - master audio mode drives word clock on general pin one
// - master audio mode drives serial data on general pin zero
// - master audio mode drives system clock on general pin nine
// - pin function comes only from register settings, never from pin levels
// - lock output high when PLL locked and D-PHY outputs active
// - lock output low whenever PLL is not locked
// - normal mode: pass high with no timing fault, low on fault
// - a single data-enable length mismatch is a timing fault
// - frame-sync length mismatch on two successive measurements is a timing fault
// - self-test mode: pass high without test error, low once one is seen
// - after reset register-controlled pins act as outputs driving low
package apms_pkg;

   localparam int APMS_AW = 8;
   localparam int APMS_DW = 32;

   // register byte offsets
   localparam logic [7:0] APMS_OFF_CTRL     = 8'h00;
   localparam logic [7:0] APMS_OFF_GPIO_OUT = 8'h04;
   localparam logic [7:0] APMS_OFF_GPIO_OE  = 8'h08;
   localparam logic [7:0] APMS_OFF_STATUS   = 8'h0C;
   localparam logic [7:0] APMS_OFF_INT_STAT = 8'h10;
   localparam logic [7:0] APMS_OFF_INT_MASK = 8'h14;
   localparam logic [7:0] APMS_OFF_GPIO_IN  = 8'h18;
   localparam logic [7:0] APMS_OFF_CMD      = 8'h1C;

   // control fields
   localparam int APMS_CTRL_MODE_LSB = 0;
   localparam int APMS_CTRL_BIST     = 2;
   localparam int APMS_CTRL_JCDIS    = 7;

   // status fields
   localparam int APMS_STS_LOCK   = 0;
   localparam int APMS_STS_PASS   = 1;
   localparam int APMS_STS_TFAULT = 2;
   localparam int APMS_STS_BERR   = 3;

   // interrupt fields
   localparam int APMS_IRQ_N       = 3;
   localparam int APMS_IRQ_LOCKLOS = 0;
   localparam int APMS_IRQ_TFAULT  = 1;
   localparam int APMS_IRQ_BERR    = 2;

   // command fields (self-clearing)
   localparam int APMS_CMD_CLR_TFAULT = 0;
   localparam int APMS_CMD_CLR_BERR   = 1;

   // shared pin slots
   localparam int APMS_PIN_N   = 9;
   localparam int APMS_PIN_GP0 = 0;
   localparam int APMS_PIN_GP1 = 1;
   localparam int APMS_PIN_GP2 = 2;
   localparam int APMS_PIN_GP3 = 3;
   localparam int APMS_PIN_GP9 = 4;
   localparam int APMS_PIN_RG5 = 5;
   localparam int APMS_PIN_RG6 = 6;
   localparam int APMS_PIN_RG7 = 7;
   localparam int APMS_PIN_RG8 = 8;

   // reset values
   localparam logic [APMS_PIN_N-1:0] APMS_RST_GPIO_OUT = 9'h000;
   localparam logic [APMS_PIN_N-1:0] APMS_RST_GPIO_OE  = 9'h1E0;
   localparam logic [APMS_IRQ_N-1:0] APMS_RST_INT_MASK = 3'h0;

   // timing check
   localparam int APMS_LEN_W     = 16;
   localparam int APMS_DE_NEED   = 1;
   localparam int APMS_FSYN_NEED = 2;

   typedef enum logic [1:0] {
      APMS_MODE_GPIO   = 2'b00,
      APMS_MODE_SLAVE  = 2'b01,
      APMS_MODE_MASTER = 2'b10
   } apms_mode_t;

endpackage

// >>> rtl/apms_len_chk.sv
// length measurement of a high period with mismatch detection against the last length
`timescale 1ns/100ps
`default_nettype none
module apms_len_chk
   import apms_pkg::*;
#(
   parameter int CW   = APMS_LEN_W,
   parameter int NEED = 1
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic en,
   input  wire logic level,
   output logic      mismatch
);
   localparam int MW = $clog2(NEED + 1);
   localparam logic [MW-1:0] NEED_V = MW'(NEED);

   logic          level_d_r, level_d_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [CW-1:0] ref_r, ref_nxt;
   logic          ref_ok_r, ref_ok_nxt;
   logic [MW-1:0] miss_r, miss_nxt;
   logic          mis_r, mis_nxt;

   always_comb begin
      level_d_nxt = level;
      cnt_nxt     = cnt_r;
      ref_nxt     = ref_r;
      ref_ok_nxt  = ref_ok_r;
      miss_nxt    = miss_r;
      mis_nxt     = 1'b0;
      if (level) begin
         if (!level_d_r) begin
            cnt_nxt = {{(CW-1){1'b0}}, 1'b1};
         end else if (cnt_r != {CW{1'b1}}) begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
      if (level_d_r && !level) begin
         if (ref_ok_r && (cnt_r != ref_r)) begin
            miss_nxt = miss_r + 1'b1;
            // one mismatch or several in a row, per instance
            if (miss_nxt == NEED_V) begin
               mis_nxt  = 1'b1;
               miss_nxt = '0;
            end
         end else begin
            miss_nxt = '0;
         end
         ref_nxt    = cnt_r;
         ref_ok_nxt = 1'b1;
      end
      // a stale reference after a pause would give a false fault
      if (!en) begin
         ref_ok_nxt = 1'b0;
         miss_nxt   = '0;
         mis_nxt    = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_d_r <= 1'b0;
         cnt_r     <= '0;
         ref_r     <= '0;
         ref_ok_r  <= 1'b0;
         miss_r    <= '0;
         mis_r     <= 1'b0;
      end else if (ce) begin
         level_d_r <= level_d_nxt;
         cnt_r     <= cnt_nxt;
         ref_r     <= ref_nxt;
         ref_ok_r  <= ref_ok_nxt;
         miss_r    <= miss_nxt;
         mis_r     <= mis_nxt;
      end
   end

   assign mismatch = mis_r;

endmodule
`default_nettype wire

// >>> rtl/apms_top.sv
// audio pin multiplexer with lock and pass status outputs, registers on APB
`timescale 1ns/100ps
`default_nettype none
module apms_top
   import apms_pkg::*;
#(
   parameter int LEN_W = APMS_LEN_W
) (
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire logic                  CE,
   input  wire logic [APMS_AW-1:0]    PADDR,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [APMS_DW-1:0]    PWDATA,
   output logic      [APMS_DW-1:0]    PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   input  wire logic                  SLAVE_WORD_CLOCK_IN,
   input  wire logic                  SLAVE_BIT_CLOCK_IN,
   input  wire logic                  SLAVE_AUDIO_DATA_A_IN,
   input  wire logic                  SLAVE_AUDIO_DATA_B_IN,
   input  wire logic                  SLAVE_AUDIO_DATA_C_IN,
   input  wire logic                  SLAVE_AUDIO_DATA_D_IN,
   input  wire logic                  MASTER_WORD_CLOCK_IN,
   input  wire logic                  MASTER_AUDIO_DATA_IN,
   input  wire logic                  MASTER_SYS_CLOCK_IN,
   input  wire logic [APMS_PIN_N-1:0] PIN_I,
   output logic      [APMS_PIN_N-1:0] PIN_O,
   output logic      [APMS_PIN_N-1:0] PIN_OE,
   input  wire logic                  PLL_LOCKED,
   input  wire logic                  DPHY_ACTIVE,
   input  wire logic                  DATA_ENABLE,
   input  wire logic                  FRAME_SYNC,
   input  wire logic                  SELF_TEST_ERR,
   output logic                       LOCK,
   output logic                       PASS,
   output logic                       JITTER_CLEAN_DIS,
   output logic                       IRQ
);

   // ---------------- input synchronisers ----------------
   logic [APMS_PIN_N-1:0] pin_s1_r, pin_s1_nxt;
   logic [APMS_PIN_N-1:0] pin_s2_r, pin_s2_nxt;
   logic                  lock_s1_r, lock_s1_nxt;
   logic                  lock_s2_r, lock_s2_nxt;

   always_comb begin
      pin_s1_nxt  = PIN_I;
      pin_s2_nxt  = pin_s1_r;
      lock_s1_nxt = PLL_LOCKED;
      lock_s2_nxt = lock_s1_r;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_r  <= '0;
         pin_s2_r  <= '0;
         lock_s1_r <= 1'b0;
         lock_s2_r <= 1'b0;
      end else if (CE) begin
         pin_s1_r  <= pin_s1_nxt;
         pin_s2_r  <= pin_s2_nxt;
         lock_s1_r <= lock_s1_nxt;
         lock_s2_r <= lock_s2_nxt;
      end
   end

   // ---------------- timing checks ----------------
   logic de_mis;
   logic fsyn_mis;
   logic bist_r;

   apms_len_chk #(
      .CW   (LEN_W),
      .NEED (APMS_DE_NEED)
   ) u_de_chk (
      .clk      (CLK),
      .rst_n    (RST_N),
      .ce       (CE),
      .en       (!bist_r),
      .level    (DATA_ENABLE),
      .mismatch (de_mis)
   );

   apms_len_chk #(
      .CW   (LEN_W),
      .NEED (APMS_FSYN_NEED)
   ) u_fsyn_chk (
      .clk      (CLK),
      .rst_n    (RST_N),
      .ce       (CE),
      .en       (!bist_r),
      .level    (FRAME_SYNC),
      .mismatch (fsyn_mis)
   );

   // ---------------- registers and APB slave ----------------
   apms_mode_t            mode_r, mode_nxt;
   logic                  bist_nxt;
   logic                  jcdis_r, jcdis_nxt;
   logic [APMS_PIN_N-1:0] gpio_out_r, gpio_out_nxt;
   logic [APMS_PIN_N-1:0] gpio_oe_r, gpio_oe_nxt;
   logic [APMS_IRQ_N-1:0] int_stat_r, int_stat_nxt;
   logic [APMS_IRQ_N-1:0] int_mask_r, int_mask_nxt;
   logic                  pready_r, pready_nxt;
   logic [APMS_DW-1:0]    prdata_r, prdata_nxt;
   logic                  pslverr_r, pslverr_nxt;
   logic                  irq_r, irq_nxt;
   logic                  lock_r, lock_nxt;
   logic                  pass_r, pass_nxt;
   logic                  tfault_r, tfault_nxt;
   logic                  berr_r, berr_nxt;
   logic [APMS_PIN_N-1:0] pin_o_r, pin_o_nxt;
   logic [APMS_PIN_N-1:0] pin_oe_r, pin_oe_nxt;

   logic                  acc;
   logic                  wr_done;
   logic                  mapped;
   logic                  clr_tfault;
   logic                  clr_berr;
   logic [APMS_IRQ_N-1:0] int_set;
   logic [APMS_IRQ_N-1:0] int_clr;
   logic [APMS_DW-1:0]    rd_val;

   always_comb begin
      // first access cycle prepares data, second one completes
      acc         = PSEL && PENABLE;
      pready_nxt  = acc && !pready_r;
      wr_done     = acc && pready_r && PWRITE;
      mode_nxt    = mode_r;
      bist_nxt    = bist_r;
      jcdis_nxt   = jcdis_r;
      gpio_out_nxt = gpio_out_r;
      gpio_oe_nxt = gpio_oe_r;
      int_mask_nxt = int_mask_r;
      clr_tfault  = 1'b0;
      clr_berr    = 1'b0;
      int_clr     = '0;
      mapped      = 1'b1;
      rd_val      = '0;

      unique case (PADDR)
         APMS_OFF_CTRL: begin
            rd_val[APMS_CTRL_MODE_LSB +: 2] = mode_r;
            rd_val[APMS_CTRL_BIST]          = bist_r;
            rd_val[APMS_CTRL_JCDIS]         = jcdis_r;
         end
         APMS_OFF_GPIO_OUT: rd_val[APMS_PIN_N-1:0] = gpio_out_r;
         APMS_OFF_GPIO_OE:  rd_val[APMS_PIN_N-1:0] = gpio_oe_r;
         APMS_OFF_STATUS: begin
            rd_val[APMS_STS_LOCK]   = lock_r;
            rd_val[APMS_STS_PASS]   = pass_r;
            rd_val[APMS_STS_TFAULT] = tfault_r;
            rd_val[APMS_STS_BERR]   = berr_r;
         end
         APMS_OFF_INT_STAT: rd_val[APMS_IRQ_N-1:0] = int_stat_r;
         APMS_OFF_INT_MASK: rd_val[APMS_IRQ_N-1:0] = int_mask_r;
         // pin levels are only reported, they never steer the mux
         APMS_OFF_GPIO_IN:  rd_val[APMS_PIN_N-1:0] = pin_s2_r;
         APMS_OFF_CMD:      rd_val = '0;
         default:           mapped = 1'b0;
      endcase

      if (wr_done && mapped) begin
         unique case (PADDR)
            APMS_OFF_CTRL: begin
               mode_nxt  = apms_mode_t'(PWDATA[APMS_CTRL_MODE_LSB +: 2]);
               bist_nxt  = PWDATA[APMS_CTRL_BIST];
               jcdis_nxt = PWDATA[APMS_CTRL_JCDIS];
            end
            APMS_OFF_GPIO_OUT: gpio_out_nxt = PWDATA[APMS_PIN_N-1:0];
            APMS_OFF_GPIO_OE:  gpio_oe_nxt  = PWDATA[APMS_PIN_N-1:0];
            APMS_OFF_INT_STAT: int_clr      = PWDATA[APMS_IRQ_N-1:0];
            APMS_OFF_INT_MASK: int_mask_nxt = PWDATA[APMS_IRQ_N-1:0];
            APMS_OFF_CMD: begin
               clr_tfault = PWDATA[APMS_CMD_CLR_TFAULT];
               clr_berr   = PWDATA[APMS_CMD_CLR_BERR];
            end
            default: ;
         endcase
      end

      prdata_nxt  = (pready_nxt && !PWRITE && mapped) ? rd_val : '0;
      pslverr_nxt = pready_nxt && !mapped;

      // lock needs both the PLL and the D-PHY outputs
      lock_nxt = lock_s2_r && DPHY_ACTIVE;

      // a hardware event in the clear cycle survives
      tfault_nxt = (tfault_r && !clr_tfault) || (!bist_r && (de_mis || fsyn_mis));
      berr_nxt   = (berr_r && !clr_berr) || (bist_r && SELF_TEST_ERR);
      pass_nxt   = bist_r ? !berr_nxt : !tfault_nxt;

      int_set                   = '0;
      int_set[APMS_IRQ_LOCKLOS] = lock_r && !lock_nxt;
      int_set[APMS_IRQ_TFAULT]  = tfault_nxt && !tfault_r;
      int_set[APMS_IRQ_BERR]    = berr_nxt && !berr_r;
      int_stat_nxt = (int_stat_r & ~int_clr) | int_set;
      irq_nxt      = |(int_stat_nxt & int_mask_nxt);
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_r     <= APMS_MODE_GPIO;
         bist_r     <= 1'b0;
         jcdis_r    <= 1'b0;
         gpio_out_r <= APMS_RST_GPIO_OUT;
         gpio_oe_r  <= APMS_RST_GPIO_OE;
         int_stat_r <= '0;
         int_mask_r <= APMS_RST_INT_MASK;
         pready_r   <= 1'b0;
         prdata_r   <= '0;
         pslverr_r  <= 1'b0;
         irq_r      <= 1'b0;
         lock_r     <= 1'b0;
         pass_r     <= 1'b1;
         tfault_r   <= 1'b0;
         berr_r     <= 1'b0;
      end else if (CE) begin
         mode_r     <= mode_nxt;
         bist_r     <= bist_nxt;
         jcdis_r    <= jcdis_nxt;
         gpio_out_r <= gpio_out_nxt;
         gpio_oe_r  <= gpio_oe_nxt;
         int_stat_r <= int_stat_nxt;
         int_mask_r <= int_mask_nxt;
         pready_r   <= pready_nxt;
         prdata_r   <= prdata_nxt;
         pslverr_r  <= pslverr_nxt;
         irq_r      <= irq_nxt;
         lock_r     <= lock_nxt;
         pass_r     <= pass_nxt;
         tfault_r   <= tfault_nxt;
         berr_r     <= berr_nxt;
      end
   end

   // ---------------- pin multiplexer ----------------
   always_comb begin
      pin_o_nxt  = gpio_out_r;
      pin_oe_nxt = gpio_oe_r;
      // selection depends on mode_r only, so pin levels cannot feed back
      unique case (mode_r)
         APMS_MODE_GPIO: ;
         APMS_MODE_SLAVE: begin
            pin_o_nxt[APMS_PIN_RG7]  = SLAVE_WORD_CLOCK_IN;
            pin_o_nxt[APMS_PIN_RG8]  = SLAVE_BIT_CLOCK_IN;
            pin_o_nxt[APMS_PIN_RG6]  = SLAVE_AUDIO_DATA_A_IN;
            pin_o_nxt[APMS_PIN_RG5]  = SLAVE_AUDIO_DATA_B_IN;
            pin_o_nxt[APMS_PIN_GP2]  = SLAVE_AUDIO_DATA_C_IN;
            pin_o_nxt[APMS_PIN_GP3]  = SLAVE_AUDIO_DATA_D_IN;
            pin_oe_nxt[APMS_PIN_RG7] = 1'b1;
            pin_oe_nxt[APMS_PIN_RG8] = 1'b1;
            pin_oe_nxt[APMS_PIN_RG6] = 1'b1;
            pin_oe_nxt[APMS_PIN_RG5] = 1'b1;
            pin_oe_nxt[APMS_PIN_GP2] = 1'b1;
            pin_oe_nxt[APMS_PIN_GP3] = 1'b1;
         end
         APMS_MODE_MASTER: begin
            pin_o_nxt[APMS_PIN_GP1]  = MASTER_WORD_CLOCK_IN;
            pin_o_nxt[APMS_PIN_GP0]  = MASTER_AUDIO_DATA_IN;
            pin_o_nxt[APMS_PIN_GP9]  = MASTER_SYS_CLOCK_IN;
            pin_oe_nxt[APMS_PIN_GP1] = 1'b1;
            pin_oe_nxt[APMS_PIN_GP0] = 1'b1;
            pin_oe_nxt[APMS_PIN_GP9] = 1'b1;
         end
         // the unused code falls back to plain GPIO
         default: ;
      endcase
   end

   // outputs are re-registered, audio clocks lag the engine by one cycle
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_o_r  <= APMS_RST_GPIO_OUT;
         pin_oe_r <= APMS_RST_GPIO_OE;
      end else if (CE) begin
         pin_o_r  <= pin_o_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   assign PIN_O            = pin_o_r;
   assign PIN_OE           = pin_oe_r;
   assign PRDATA           = prdata_r;
   assign PREADY           = pready_r;
   assign PSLVERR          = pslverr_r;
   assign LOCK             = lock_r;
   assign PASS             = pass_r;
   assign JITTER_CLEAN_DIS = jcdis_r;
   assign IRQ              = irq_r;

endmodule
`default_nettype wire

// >>> verification/apms_pin_model.sv
// far-side pin model: resolves each shared pin as the codec and host see it
`timescale 1ns/100ps
`default_nettype none
module apms_pin_model
   import apms_pkg::*;
(
   input  wire logic [APMS_PIN_N-1:0] pin_o,
   input  wire logic [APMS_PIN_N-1:0] pin_oe,
   input  wire logic [APMS_PIN_N-1:0] ext_val,
   input  wire logic [APMS_PIN_N-1:0] ext_oe,
   output logic      [APMS_PIN_N-1:0] pin_lvl
);
   // released pins fall to the weak pull-down, never hold the last value
   always_comb begin
      for (int i = 0; i < APMS_PIN_N; i++) begin
         pin_lvl[i] = pin_oe[i] ? pin_o[i] : (ext_oe[i] & ext_val[i]);
      end
   end
endmodule
`default_nettype wire

// >>> verification/apms_monitor.sv
// concurrent checks on the ports of the audio pin mux and status block
`timescale 1ns/100ps
`default_nettype none
module apms_monitor
   import apms_pkg::*;
(
   input wire logic                  CLK,
   input wire logic                  RST_N,
   input wire logic [APMS_AW-1:0]    PADDR,
   input wire logic                  PSEL,
   input wire logic                  PENABLE,
   input wire logic                  PWRITE,
   input wire logic [APMS_DW-1:0]    PWDATA,
   input wire logic                  PREADY,
   input wire logic                  SLAVE_BIT_CLOCK_IN,
   input wire logic                  SLAVE_AUDIO_DATA_A_IN,
   input wire logic                  MASTER_WORD_CLOCK_IN,
   input wire logic                  MASTER_AUDIO_DATA_IN,
   input wire logic                  MASTER_SYS_CLOCK_IN,
   input wire logic [APMS_PIN_N-1:0] PIN_O,
   input wire logic [APMS_PIN_N-1:0] PIN_OE,
   input wire logic                  PLL_LOCKED,
   input wire logic                  DPHY_ACTIVE,
   input wire logic                  SELF_TEST_ERR,
   input wire logic                  LOCK,
   input wire logic                  PASS
);
   logic [1:0] mode_r;
   logic [1:0] mode_nxt;
   logic       bist_r;
   logic       bist_nxt;
   // shadow of the control word, taken at the completing edge
   always_comb begin
      mode_nxt = mode_r;
      bist_nxt = bist_r;
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == APMS_OFF_CTRL) begin
         mode_nxt = PWDATA[1:0];
         bist_nxt = PWDATA[APMS_CTRL_BIST];
      end
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_r <= 2'h0;
         bist_r <= 1'h0;
      end else begin
         mode_r <= mode_nxt;
         bist_r <= bist_nxt;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_wait;
      !PREADY ##1 PREADY;
   endsequence
   sequence s_synced;
      (PLL_LOCKED && DPHY_ACTIVE) [*4];
   endsequence
   chk_apb_wait: assert property (PSEL && !PENABLE |=> s_wait)
      else $error("apb access without exactly one wait state");
   chk_lock_rise: assert property (s_synced |=> LOCK)
      else $error("lock output stayed low");
   chk_lock_dphy: assert property (!DPHY_ACTIVE |=> !LOCK)
      else $error("lock high with output stage idle");
   chk_lock_drop: assert property ((!PLL_LOCKED) [*3] |=> !LOCK)
      else $error("lock high while pll unlocked");
   chk_slave_bclk: assert property (mode_r == APMS_MODE_SLAVE |=>
      PIN_O[APMS_PIN_RG8] == $past(SLAVE_BIT_CLOCK_IN))
      else $error("bit clock not on its pin");
   chk_slave_data: assert property (mode_r == APMS_MODE_SLAVE |=>
      PIN_O[APMS_PIN_RG6] == $past(SLAVE_AUDIO_DATA_A_IN) && PIN_OE[8:5] == 4'hF
      && PIN_OE[3:2] == 2'h3)
      else $error("slave audio pins wrong");
   chk_master_pins: assert property (mode_r == APMS_MODE_MASTER |=>
      PIN_O[1] == $past(MASTER_WORD_CLOCK_IN) && PIN_O[0] == $past(MASTER_AUDIO_DATA_IN)
      && PIN_O[4] == $past(MASTER_SYS_CLOCK_IN) && PIN_OE[1:0] == 2'h3 && PIN_OE[4])
      else $error("master audio pins wrong");
   chk_bist_pass: assert property (bist_r && SELF_TEST_ERR |-> ##[1:3] !PASS)
      else $error("pass high after test error");
   chk_reset_pins: assert property ($rose(RST_N) |->
      PIN_O == 9'h000 && PIN_OE == APMS_RST_GPIO_OE)
      else $error("pins not low after reset");
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the audio pin mux and status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import apms_pkg::*;
   logic        CLK, RST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
   logic        PLL_LOCKED, DPHY_ACTIVE, DATA_ENABLE, FRAME_SYNC, SELF_TEST_ERR;
   logic        LOCK, PASS, JITTER_CLEAN_DIS, tf, berr, lk;
   logic [7:0]  PADDR, ctrl;
   logic [31:0] PWDATA, PRDATA;
   logic [8:0]  au, PIN_I, PIN_O, PIN_OE, ext_val, ext_oe, gout, goe;
   logic [2:0]  istat, mask;
   int          last[2], fsbad, bad_count, n_checks, cyc;
   // reset-value reads, with an unmapped and a misaligned address among them
   logic [7:0]  rv_list[6] = '{APMS_OFF_CTRL, APMS_OFF_GPIO_OE, APMS_OFF_INT_MASK,
                               APMS_OFF_CMD, 8'h20, 8'h06};
   apms_top #(.LEN_W(16)) u_dut (
      .CLK, .RST_N, .CE, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA, .PRDATA, .PREADY,
      .PSLVERR, .SLAVE_WORD_CLOCK_IN(au[0]), .SLAVE_BIT_CLOCK_IN(au[1]),
      .SLAVE_AUDIO_DATA_A_IN(au[2]), .SLAVE_AUDIO_DATA_B_IN(au[3]),
      .SLAVE_AUDIO_DATA_C_IN(au[4]), .SLAVE_AUDIO_DATA_D_IN(au[5]),
      .MASTER_WORD_CLOCK_IN(au[6]), .MASTER_AUDIO_DATA_IN(au[7]),
      .MASTER_SYS_CLOCK_IN(au[8]), .PIN_I, .PIN_O, .PIN_OE, .PLL_LOCKED, .DPHY_ACTIVE,
      .DATA_ENABLE, .FRAME_SYNC, .SELF_TEST_ERR, .LOCK, .PASS, .JITTER_CLEAN_DIS, .IRQ);
   apms_pin_model u_pins (.pin_o(PIN_O), .pin_oe(PIN_OE), .ext_val, .ext_oe, .pin_lvl(PIN_I));
   initial begin
      CLK = 1'h0;
      forever #5 CLK = ~CLK;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [17:0] pins(input logic [1:0] m, input logic [8:0] a);
      logic [8:0] o;
      logic [8:0] e;
      o = gout;
      e = goe;
      if (m == 2'h1) begin
         {o[8], o[7], o[6], o[5], o[3], o[2]} = {a[1], a[0], a[2], a[3], a[5], a[4]};
         e = e | 9'h1EC;
      end else if (m == 2'h2) begin
         {o[4], o[1], o[0]} = {a[8], a[6], a[7]};
         e = e | 9'h013;
      end
      return {e, o};
   endfunction
   function automatic logic [31:0] rv(input logic [7:0] a);
      logic [17:0] p;
      p = pins(ctrl[1:0], au);
      case (a)
         APMS_OFF_CTRL:     return {24'h0, ctrl & 8'h87};
         APMS_OFF_GPIO_OUT: return {23'h0, gout};
         APMS_OFF_GPIO_OE:  return {23'h0, goe};
         APMS_OFF_STATUS:   return {28'h0, berr, tf, ctrl[2] ? !berr : !tf, lk};
         APMS_OFF_INT_STAT: return {29'h0, istat};
         APMS_OFF_INT_MASK: return {29'h0, mask};
         APMS_OFF_GPIO_IN:  return {23'h0, (p[17:9] & p[8:0]) | (~p[17:9] & ext_oe & ext_val)};
         default:           return 32'h0;
      endcase
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      case (a)
         APMS_OFF_CTRL: begin
            // leaving self-test drops the stored references
            if (ctrl[2] && !d[2]) last = '{-1, -1};
            ctrl = d[7:0];
         end
         APMS_OFF_GPIO_OUT: gout = d[8:0];
         APMS_OFF_GPIO_OE:  goe = d[8:0];
         APMS_OFF_INT_STAT: istat = istat & ~d[2:0];
         APMS_OFF_INT_MASK: mask = d[2:0];
         APMS_OFF_CMD: begin
            tf = tf & !d[0];
            berr = berr & !d[1];
         end
         default: ;
      endcase
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      int          n;
      @(posedge CLK);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'h1;
      n = 0;
      // pready is read at the edge, before that edge updates it
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'h1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      chk("wait_states", 32'(n), 32'h2);
      chk("pslverr", 32'(er), 32'(a > 8'h1C || a[1:0] != 2'h0));
      if (!w) chk("prdata", rd, rv(a));
      if (w && er !== 1'h1) wr(a, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic irq_chk();
      tick(2);
      chk("irq", 32'(IRQ), 32'(|(istat & mask)));
      chk("lock", 32'(LOCK), 32'(lk));
   endtask
   task automatic pulse(input int s, input int n);
      repeat (n) begin
         @(posedge CLK);
         if (s == 0) DATA_ENABLE <= 1'h1;
         else FRAME_SYNC <= 1'h1;
      end
      @(posedge CLK);
      DATA_ENABLE <= 1'h0;
      FRAME_SYNC <= 1'h0;
      if (last[s] >= 0 && last[s] != n) begin
         fsbad = fsbad + s;
         if (s == 0 || fsbad >= 2) begin
            istat[1] = istat[1] | !tf;
            tf = 1'h1;
            fsbad = s ? 0 : fsbad;
         end
      end else if (s == 1) fsbad = 0;
      last[s] = n;
      tick(4);
      chk("pass", 32'(PASS), 32'(ctrl[2] ? !berr : !tf));
   endtask
   task automatic err_pulse();
      @(posedge CLK);
      SELF_TEST_ERR <= 1'h1;
      @(posedge CLK);
      SELF_TEST_ERR <= 1'h0;
      // error input only counts in self-test
      if (ctrl[2]) begin
         istat[2] = istat[2] | !berr;
         berr = 1'h1;
      end
      tick(3);
      chk("pass", 32'(PASS), 32'(ctrl[2] ? !berr : !tf));
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      {CE, RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'h1, 1'h0, 43'h0};
      {PLL_LOCKED, DPHY_ACTIVE, DATA_ENABLE, FRAME_SYNC, SELF_TEST_ERR} = 5'h00;
      {au, ext_val, ext_oe, gout, ctrl, istat, mask, tf, berr, lk} = 53'h0;
      goe = APMS_RST_GPIO_OE;
      last = '{-1, -1};
      void'($urandom(32'h34C4));
      tick(12);
      RST_N <= 1'h1;
      tick(1);
      chk("pin_oe", 32'(PIN_OE), 32'(APMS_RST_GPIO_OE));
      chk("pin_o", 32'(PIN_O), 32'h0);
      foreach (rv_list[i]) bus(1'h0, rv_list[i], 32'h0);
      bus(1'h1, 8'h24, 32'hFFFFFFFF);
      $display("test reset done");
      bus(1'h1, APMS_OFF_GPIO_OUT, $urandom);
      bus(1'h1, APMS_OFF_GPIO_OE, $urandom);
      for (int m = 0; m < 4; m++) begin
         bus(1'h1, APMS_OFF_CTRL, m == 1 ? 32'h81 : 32'(m));
         repeat (8) begin
            au <= 9'($urandom);
            ext_val <= 9'($urandom);
            ext_oe <= 9'($urandom);
            tick(2);
            chk("pins", 32'({PIN_OE, PIN_O}), 32'(pins(ctrl[1:0], au)));
         end
         chk("jit_dis", 32'(JITTER_CLEAN_DIS), 32'(ctrl[7]));
         tick(3);
         bus(1'h0, APMS_OFF_GPIO_IN, 32'h0);
      end
      bus(1'h1, APMS_OFF_CTRL, 32'h0);
      $display("test mux done");
      bus(1'h1, APMS_OFF_INT_MASK, 32'h1);
      {PLL_LOCKED, DPHY_ACTIVE, lk} <= 3'h7;
      tick(5);
      bus(1'h0, APMS_OFF_STATUS, 32'h0);
      DPHY_ACTIVE <= 1'h0;
      {lk, istat[0]} = 2'h1;
      irq_chk();
      {DPHY_ACTIVE, lk} <= 2'h3;
      tick(3);
      PLL_LOCKED <= 1'h0;
      lk = 1'h0;
      tick(4);
      irq_chk();
      bus(1'h0, APMS_OFF_INT_STAT, 32'h0);
      for (int i = 0; i < 3; i++) begin
         bus(1'h1, i == 2 ? APMS_OFF_INT_STAT : APMS_OFF_INT_MASK, 32'((i + 1) / 2));
         irq_chk();
      end
      $display("test lock done");
      pulse(0, 5);
      pulse(0, 5);
      pulse(0, 6);
      bus(1'h0, APMS_OFF_STATUS, 32'h0);
      bus(1'h1, APMS_OFF_CMD, 32'h1);
      pulse(1, 5);
      pulse(1, 5);
      pulse(1, 6);
      pulse(1, 7);
      bus(1'h1, APMS_OFF_CMD, 32'h1);
      err_pulse();
      bus(1'h1, APMS_OFF_CTRL, 32'h4);
      err_pulse();
      bus(1'h0, APMS_OFF_STATUS, 32'h0);
      bus(1'h1, APMS_OFF_CMD, 32'h2);
      bus(1'h0, APMS_OFF_STATUS, 32'h0);
      bus(1'h0, APMS_OFF_INT_STAT, 32'h0);
      $display("test status done");
      conclude();
   end
endmodule
bind apms_top apms_monitor u_mon (.CLK, .RST_N, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA,
   .PREADY, .SLAVE_BIT_CLOCK_IN, .SLAVE_AUDIO_DATA_A_IN, .MASTER_WORD_CLOCK_IN,
   .MASTER_AUDIO_DATA_IN, .MASTER_SYS_CLOCK_IN, .PIN_O, .PIN_OE, .PLL_LOCKED,
   .DPHY_ACTIVE, .SELF_TEST_ERR, .LOCK, .PASS);
`default_nettype wire
